// ==== common/port_pkg.sv ====
// Shared constants and types for the slave FIFO and command port
package port_pkg;
  // Select codes and endpoint memory layout
  localparam logic [2:0] SEL_CMD = 3'h4;
  localparam int unsigned NUM_EP = 4;
  localparam int unsigned FILL_W = 12;
  localparam logic [11:0] FIFO_BYTES = 12'h400;
  localparam logic [11:0] PKT_FILL = 12'h200;
  localparam logic [9:0] MAX_PKT = 10'h200;
  localparam logic [3:0] EP_IS_IN = 4'hC;
  // Command byte fields
  localparam int unsigned CB_ADDR_FLAG = 7;
  localparam int unsigned CB_READ = 6;
  localparam int unsigned CB_ADDR_MSB = 5;
  localparam int unsigned NIB_MSB = 3;
  localparam logic [2:0] CMD_BUSY = 3'h2;
  // Register addresses on the command channel
  localparam logic [5:0] RA_IFCFG = 6'h01;
  localparam logic [5:0] RA_COMMIT_POLARITY_REG = 6'h04;
  localparam logic [5:0] RA_PINPOL = 6'h09;
  localparam logic [15:0] PINPOL_XDATA = 16'hE609;
  localparam logic [5:0] RA_FLAGMAP = 6'h0A;
  localparam logic [5:0] RA_WIDTH_BASE = 6'h10;
  localparam logic [5:0] RA_PF_BASE = 6'h18;
  localparam logic [5:0] RA_FILL_BASE = 6'h20;
  // Bit positions
  localparam int unsigned IFC_INT_CLK = 7;
  localparam int unsigned IFC_48 = 6;
  localparam int unsigned IFC_INV = 4;
  localparam int unsigned IFC_ASYNC = 3;
  localparam int unsigned POL_COMMIT = 5;
  localparam int unsigned PP_WR = 2;
  localparam int unsigned PP_RD = 3;
  localparam int unsigned PP_OE = 4;
  localparam int unsigned PFH_DIR = 7;
  localparam int unsigned PFH_PACKET_STATUS_MODE = 6;
  localparam int unsigned FM_FIXED = 2;
  // Reset values and internal clock half periods, less one, in core cycles
  localparam logic [7:0] PFH_OUT_RESET = 8'h82;
  localparam logic [7:0] PFH_IN_RESET = 8'h02;
  localparam logic [1:0] HALF_30 = 2'h1;
  localparam logic [1:0] HALF_48 = 2'h0;
  typedef enum logic [1:0] {CMD_IDLE = 2'b00, CMD_HI = 2'b01, CMD_LO = 2'b10} cmd_state_t;
  typedef struct packed {
    logic [2:0] sel;
    logic cs_n;
    logic rd;
    logic wr;
    logic oe;
    logic commit;
    logic interface_clock;
    logic [15:0] data;
  } pins_t;
  localparam pins_t PINS_IDLE = {3'h0, 6'h3E, 16'h0000};
  typedef struct packed {
    logic [1:0] ep;
    logic wide;
    logic [15:0] data;
  } tx_word_t;
  typedef struct packed {
    logic prev_rd, prev_wr, prev_cm, prev_clk, clk_gen;
    logic [1:0] div;
    logic [7:0] ifcfg, commit_polarity_reg, pinpol, flagmap;
    logic [NUM_EP-1:0] wide;
    logic [NUM_EP-1:0][7:0] pf_hi;
    logic [NUM_EP-1:0][7:0] pf_lo;
    logic [NUM_EP-1:0][FILL_W-1:0] fill;
    logic [NUM_EP-1:0][9:0] pkt_bytes;
    logic [NUM_EP-1:0][2:0] done;
    cmd_state_t cst;
    logic [5:0] cmd_addr;
    logic [3:0] nib;
    logic [7:0] rdata, status;
    logic rd_wait;
    logic [2:0] busy;
    logic ready, irq_n, data_oe_n, flag_a, flag_b, flag_c, out_pop, clk_pin, clk_oe_n;
    logic [1:0] out_pop_ep;
    logic [15:0] data_out;
  } core_state_t;
endpackage

// ==== hw/pin_sync.sv ====
// Two-stage synchroniser for master-side pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } sync_t;
  sync_t s, next_s;

  // First stage feeds only the second
  always_comb begin
    next_s.meta = d;
    next_s.q = s.meta;
  end

  // Register both stages
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s <= {RESET_VAL, RESET_VAL};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule
`default_nettype wire

// ==== hw/word_buffer.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_buffer #(
  parameter int unsigned WIDTH = 19
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0] v;
    logic [1:0][WIDTH-1:0] d;
  } buf_t;
  buf_t s, next_s;

  // Entry zero is always the head; entry one takes the overflow
  always_comb begin
    next_s = s;
    if (out_ready && s.v[0]) begin
      next_s.v = {1'b0, s.v[1]};
      next_s.d[0] = s.d[1];
    end
    if (in_valid && !s.v[1]) begin
      if (!next_s.v[0]) begin
        next_s.v[0] = 1'b1;
        next_s.d[0] = in_data;
      end else begin
        next_s.v[1] = 1'b1;
        next_s.d[1] = in_data;
      end
    end
  end

  // Register the entries
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Ready depends only on stored state
  assign in_ready = !s.v[1];
  assign out_valid = s.v[0];
  assign out_data = s.d[0];
endmodule
`default_nettype wire

// ==== hw/slave_fifo_command_port.sv ====
// Slave FIFO and nibble command port facing an external master
//
// Overview of operation
// - Select 000-011 picks endpoint two to eight, 100 commands, rest reserved.
// - Synchronous reads pop per clock edge; asynchronous reads pop on strobe release.
// - The data bus is driven only while output enable is asserted.
// - Writes capture bus data per clock edge or on strobe release.
// - Packet commit sends the current IN buffer even when short.
// - Controls are active low at reset; polarity registers can flip all but chip select.
// - Config bit 7 picks internal clock, bit 6 picks its rate.
// - Config bit 4 inverts the interface clock, input or output.
// - Inactive chip select floats the bus and ignores strobes and commit.
// - Bus width is 8 or 16 bits per endpoint width bit.
// - Flags a, b, c give programmable, full, empty; pin d is chip select.
// - Fixed flags watch one FIFO; indexed flags follow the select lines.
// - By default OUT flags at 512 bytes or more, IN at 512 or less.
// - OUT flag compares total byte count against a 13-bit threshold.
// - IN flag with packet status set compares current packet bytes.
// - IN flag otherwise compares committed packets plus current bytes.
// - Commands use low byte; bit 7 address, bit 6 read, bits 5-0 address.
// - A new address byte discards an unfinished write.
// - Each value goes as two data bytes, upper nibble first.
// - Command channel shares pins except commit; adds ready and interrupt.
// - At reset endpoints two, four are OUT and six, eight are IN.
// - Ready drops after each command byte and returns when free.
// - After a read address byte the interrupt shows data waiting.
// - Reading the status byte clears the pending interrupt.
`timescale 1ns/10ps
`default_nettype none
module slave_fifo_command_port #(
  parameter logic [2:0] CMD_BUSY_CYCLES = port_pkg::CMD_BUSY
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // Master-side control pins
  input wire logic [2:0] port_select,
  input wire logic chip_select_n,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic bus_output_enable,
  input wire logic packet_commit,
  // Interface clock pin
  input wire logic interface_clock_in,
  output logic interface_clock_out,
  output logic interface_clock_oe_n,
  // Data bus pin
  input wire logic [15:0] port_data_in,
  output logic [15:0] port_data_out,
  output logic port_data_oe_n,
  // Flags, ready and interrupt
  output logic flag_out_a,
  output logic flag_out_b,
  output logic flag_out_c,
  output logic ready,
  output logic irq_n,
  // Endpoint side: IN words toward USB
  output port_pkg::tx_word_t tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  // Endpoint side: OUT data and packet traffic
  input wire logic [15:0] out_head,
  output logic out_pop,
  output logic [1:0] out_pop_ep,
  input wire logic out_arrive,
  input wire logic [1:0] out_arrive_ep,
  input wire logic in_sent,
  input wire logic [1:0] in_sent_ep,
  input wire logic [7:0] event_in
);
  import port_pkg::*;

  pins_t pin_raw, pin;
  core_state_t s, next_s;
  tx_word_t push_word;
  logic push_valid, push_ready;
  logic sel_fifo, sel_cmd, live, cs_on, oe_on;
  logic rd_act, wr_act, cm_act, clk_lvl, clk_rise, async_mode;
  logic rd_ev, wr_ev, cm_ev, ep_in;
  logic [1:0] ep, fe;
  logic [1:0] step;
  logic [3:0] lo_nib;
  logic [7:0] wbyte;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and the IN word buffer

  assign pin_raw = {port_select, chip_select_n, read_strobe, write_strobe,
                    bus_output_enable, packet_commit, interface_clock_in, port_data_in};

  pin_sync #(.WIDTH($bits(pins_t)), .RESET_VAL(PINS_IDLE)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .d(pin_raw),
    .q(pin)
  );

  word_buffer #(.WIDTH($bits(tx_word_t))) u_buf (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Programmable flag level against threshold
  function automatic logic pf_hit(input logic is_in, input logic [7:0] hi,
                                  input logic [7:0] lo, input logic [FILL_W-1:0] fill,
                                  input logic [9:0] pkt, input logic [2:0] done);
    logic [12:0] thr;
    logic [12:0] lvl;
    thr = {hi[4:0], lo};
    if (!is_in) begin
      lvl = {1'b0, fill};
    end else if (hi[PFH_PACKET_STATUS_MODE]) begin
      lvl = {3'h0, pkt};
    end else begin
      lvl = {done, pkt};
    end
    return hi[PFH_DIR] ? (lvl >= thr) : (lvl <= thr);
  endfunction

  // Register read decode
  function automatic logic [7:0] read_reg(input core_state_t st, input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == RA_IFCFG) begin
      v = st.ifcfg;
    end else if (a == RA_COMMIT_POLARITY_REG) begin
      v = st.commit_polarity_reg;
    end else if (a == RA_PINPOL) begin
      v = st.pinpol;
    end else if (a == RA_FLAGMAP) begin
      v = st.flagmap;
    end else if (a[5:2] == RA_WIDTH_BASE[5:2]) begin
      v = {7'h00, st.wide[a[1:0]]};
    end else if (a[5:3] == RA_PF_BASE[5:3]) begin
      v = a[0] ? st.pf_lo[a[2:1]] : st.pf_hi[a[2:1]];
    end else if (a[5:2] == RA_FILL_BASE[5:2]) begin
      v = st.fill[a[1:0]][FILL_W-1:4];
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_s = s;
    // Select decode and pin polarity
    sel_fifo = !pin.sel[2];
    sel_cmd = pin.sel == SEL_CMD;
    ep = pin.sel[1:0];
    ep_in = EP_IS_IN[ep];
    cs_on = !pin.cs_n;
    live = cs_on && (sel_fifo || sel_cmd);
    rd_act = pin.rd ^ !s.pinpol[PP_RD];
    wr_act = pin.wr ^ !s.pinpol[PP_WR];
    cm_act = pin.commit ^ !s.commit_polarity_reg[POL_COMMIT];
    oe_on = live && (pin.oe ^ !s.pinpol[PP_OE]);
    async_mode = s.ifcfg[IFC_ASYNC];
    step = s.wide[ep] ? 2'h2 : 2'h1;
    lo_nib = pin.data[NIB_MSB:0];
    wbyte = {s.nib, lo_nib};

    // Interface clock source, divider and inversion
    if (s.ifcfg[IFC_INT_CLK]) begin
      if (s.div == 2'h0) begin
        next_s.div = s.ifcfg[IFC_48] ? HALF_48 : HALF_30;
        next_s.clk_gen = !s.clk_gen;
      end else begin
        next_s.div = s.div - 2'h1;
      end
      clk_lvl = s.clk_gen ^ s.ifcfg[IFC_INV];
    end else begin
      clk_lvl = pin.interface_clock ^ s.ifcfg[IFC_INV];
    end
    next_s.clk_pin = next_s.clk_gen ^ s.ifcfg[IFC_INV];
    next_s.clk_oe_n = !s.ifcfg[IFC_INT_CLK];
    clk_rise = clk_lvl && !s.prev_clk;
    next_s.prev_clk = clk_lvl;

    // Strobe events: clock qualifier or release edge
    rd_ev = live && (async_mode ? (s.prev_rd && !rd_act) : (clk_rise && rd_act));
    wr_ev = live && (async_mode ? (s.prev_wr && !wr_act) : (clk_rise && wr_act));
    cm_ev = live && sel_fifo && (async_mode ? (s.prev_cm && !cm_act) : (clk_rise && cm_act));
    next_s.prev_rd = rd_act;
    next_s.prev_wr = wr_act;
    next_s.prev_cm = cm_act;

    // Bus drive, command channel on the low byte
    next_s.data_oe_n = !oe_on;
    if (sel_cmd) begin
      next_s.data_out = {8'h00, s.rd_wait ? s.rdata : s.status};
    end else if (s.wide[ep]) begin
      next_s.data_out = out_head;
    end else begin
      next_s.data_out = {8'h00, out_head[7:0]};
    end

    // USB side packet traffic
    if (out_arrive && !EP_IS_IN[out_arrive_ep]
        && s.fill[out_arrive_ep] <= FIFO_BYTES - PKT_FILL) begin
      next_s.fill[out_arrive_ep] = s.fill[out_arrive_ep] + PKT_FILL;
    end
    if (in_sent && EP_IS_IN[in_sent_ep] && s.done[in_sent_ep] != 3'h0) begin
      next_s.done[in_sent_ep] = s.done[in_sent_ep] - 3'h1;
      next_s.fill[in_sent_ep] = (s.fill[in_sent_ep] > PKT_FILL) ?
                                s.fill[in_sent_ep] - PKT_FILL : 12'h000;
    end

    // Master read from an OUT FIFO
    next_s.out_pop = 1'b0;
    next_s.out_pop_ep = ep;
    if (rd_ev && sel_fifo && !ep_in && next_s.fill[ep] != 12'h000) begin
      next_s.out_pop = 1'b1;
      next_s.fill[ep] = (next_s.fill[ep] > {10'h000, step}) ?
                        next_s.fill[ep] - {10'h000, step} : 12'h000;
    end

    // Master write into an IN FIFO, auto commit at full packet
    push_valid = 1'b0;
    push_word = {ep, s.wide[ep], pin.data};
    if (wr_ev && sel_fifo && ep_in && push_ready
        && next_s.fill[ep] + {10'h000, step} <= FIFO_BYTES) begin
      push_valid = 1'b1;
      next_s.fill[ep] = next_s.fill[ep] + {10'h000, step};
      next_s.pkt_bytes[ep] = s.pkt_bytes[ep] + {8'h00, step};
      if (next_s.pkt_bytes[ep] >= MAX_PKT) begin
        next_s.pkt_bytes[ep] = 10'h000;
        next_s.done[ep] = next_s.done[ep] + 3'h1;
      end
    end

    // Short packet commit
    if (cm_ev && ep_in && next_s.pkt_bytes[ep] != 10'h000) begin
      next_s.pkt_bytes[ep] = 10'h000;
      next_s.done[ep] = next_s.done[ep] + 3'h1;
    end

    // Command byte framing
    if (s.busy != 3'h0) begin
      next_s.busy = s.busy - 3'h1;
    end
    if (wr_ev && sel_cmd && s.busy == 3'h0) begin
      next_s.busy = CMD_BUSY_CYCLES;
      if (pin.data[CB_ADDR_FLAG]) begin
        next_s.cmd_addr = pin.data[CB_ADDR_MSB:0];
        if (pin.data[CB_READ]) begin
          next_s.cst = CMD_IDLE;
          next_s.rdata = read_reg(s, pin.data[CB_ADDR_MSB:0]);
          next_s.rd_wait = 1'b1;
        end else begin
          next_s.cst = CMD_HI;
        end
      end else begin
        case (s.cst)
          CMD_HI: begin
            next_s.nib = lo_nib;
            next_s.cst = CMD_LO;
          end
          CMD_LO: begin
            next_s.cst = CMD_HI;
            if (s.cmd_addr == RA_IFCFG) begin
              next_s.ifcfg = wbyte;
            end else if (s.cmd_addr == RA_COMMIT_POLARITY_REG) begin
              next_s.commit_polarity_reg = wbyte;
            end else if (s.cmd_addr == RA_PINPOL) begin
              next_s.pinpol = wbyte;
            end else if (s.cmd_addr == RA_FLAGMAP) begin
              next_s.flagmap = wbyte;
            end else if (s.cmd_addr[5:2] == RA_WIDTH_BASE[5:2]) begin
              next_s.wide[s.cmd_addr[1:0]] = wbyte[0];
            end else if (s.cmd_addr[5:3] == RA_PF_BASE[5:3]) begin
              if (s.cmd_addr[0]) begin
                next_s.pf_lo[s.cmd_addr[2:1]] = wbyte;
              end else begin
                next_s.pf_hi[s.cmd_addr[2:1]] = wbyte;
              end
            end
          end
          default: next_s.cst = CMD_IDLE;
        endcase
      end
    end

    // Command reads: waiting data first, else the status byte
    if (rd_ev && sel_cmd) begin
      if (s.rd_wait) begin
        next_s.rd_wait = 1'b0;
      end else begin
        next_s.status = 8'h00;
      end
    end
    next_s.status = next_s.status | event_in;
    next_s.irq_n = !(next_s.rd_wait || next_s.status != 8'h00);
    next_s.ready = next_s.busy == 3'h0;

    // Flag pins for the indexed or fixed FIFO
    fe = s.flagmap[FM_FIXED] ? s.flagmap[1:0] : ep;
    next_s.flag_a = pf_hit(EP_IS_IN[fe], s.pf_hi[fe], s.pf_lo[fe], s.fill[fe],
                           s.pkt_bytes[fe], s.done[fe]);
    next_s.flag_b = s.fill[fe] >= FIFO_BYTES || (EP_IS_IN[fe] && !push_ready);
    next_s.flag_c = s.fill[fe] == 12'h000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s <= '0;
      s.pf_hi <= {PFH_IN_RESET, PFH_IN_RESET, PFH_OUT_RESET, PFH_OUT_RESET};
      s.ready <= 1'b1;
      s.irq_n <= 1'b1;
      s.data_oe_n <= 1'b1;
      s.clk_oe_n <= 1'b1;
      s.flag_c <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign interface_clock_out = s.clk_pin;
  assign interface_clock_oe_n = s.clk_oe_n;
  assign port_data_out = s.data_out;
  assign port_data_oe_n = s.data_oe_n;
  assign flag_out_a = s.flag_a;
  assign flag_out_b = s.flag_b;
  assign flag_out_c = s.flag_c;
  assign ready = s.ready;
  assign irq_n = s.irq_n;
  assign out_pop = s.out_pop;
  assign out_pop_ep = s.out_pop_ep;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_OE_GATED: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $past(ce) && !port_data_oe_n |-> $past(oe_on))
    else $error("data bus driven without output enable");

  AST_CS_QUIET: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && !cs_on |=> !out_pop && port_data_oe_n)
    else $error("activity while chip select inactive");

  AST_RESERVED_QUIET: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && pin.sel[2] && pin.sel[1:0] != 2'h0 |=> !out_pop && $stable(s.cmd_addr))
    else $error("reserved select code acted on");

  AST_READY_DROP: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && wr_ev && sel_cmd && ready |=> !ready)
    else $error("ready did not drop after command byte");

  AST_READY_RETURN: assert property (
    @(posedge core_clk) disable iff (!resetn || !ce)
    $fell(ready) |-> ##[1:8] ready)
    else $error("ready did not return");

  AST_READ_IRQ: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && wr_ev && sel_cmd && ready && pin.data[CB_ADDR_FLAG] && pin.data[CB_READ]
    |=> !irq_n && s.rd_wait)
    else $error("no interrupt after read address byte");

  AST_STATUS_CLEAR: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && rd_ev && sel_cmd && !s.rd_wait && event_in == 8'h00 |=> s.status == 8'h00)
    else $error("status read did not clear interrupt");

  AST_NIBBLE_WRITE: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && wr_ev && sel_cmd && ready && s.cst == CMD_LO && s.cmd_addr == RA_IFCFG
    && !pin.data[CB_ADDR_FLAG] |=> s.ifcfg == {$past(s.nib), $past(lo_nib)})
    else $error("nibble pair not assembled into register");

  AST_POP_ON_READ: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && rd_ev && sel_fifo && !ep_in && s.fill[ep] != 12'h000 |=> out_pop)
    else $error("read strobe did not advance OUT FIFO");
endmodule
`default_nettype wire

// ==== testbench/ep_model.sv ====
// Endpoint-side model: drains IN words with stalls and serves OUT words
`timescale 1ns/10ps
`default_nettype none
module ep_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // IN words from the port
  input wire port_pkg::tx_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic hold,
  // OUT words toward the port
  input wire logic out_pop,
  output logic [15:0] out_head,
  // Last word taken and running count
  output logic [15:0] got_data,
  output logic [1:0] got_ep,
  output logic [7:0] got_count
);
  import port_pkg::*;
  logic [2:0] phase;
  // Takes words outside the stall slots, steps the OUT head on each pop
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= 3'h0;
      got_count <= 8'h00;
      got_data <= 16'h0000;
      got_ep <= 2'h0;
      out_head <= 16'h1250;
    end else begin
      phase <= phase + 3'h1;
      if (tx_valid && tx_ready) begin
        got_count <= got_count + 8'h01;
        got_data <= tx_word.data;
        got_ep <= tx_word.ep;
      end
      if (out_pop) begin
        out_head <= out_head + 16'h0001;
      end
    end
  end
  // Stalls three cycles in eight, and fully while held
  assign tx_ready = !hold && (phase < 3'h5);
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the slave FIFO and command port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import port_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic interface_clock = 1'b0;
  logic hold = 1'b0;
  logic [2:0] port_select = 3'h0;
  logic chip_select_n = 1'b0;
  logic read_strobe = 1'b1;
  logic write_strobe = 1'b1;
  logic bus_output_enable = 1'b1;
  logic commit = 1'b1;
  logic out_arrive = 1'b0;
  logic [7:0] events = 8'h00;
  logic [1:0] arrive_ep = 2'h0;
  logic [15:0] master_data = 16'h0000;
  wire logic [15:0] bus_level;
  logic [15:0] port_data_out, out_head, got_data;
  logic port_data_oe_n, flag_out_a, flag_out_b, flag_out_c, ready, irq_n;
  logic tx_valid, tx_ready, out_pop, ready_q, clk_out, clk_oe_n;
  logic [1:0] out_pop_ep, got_ep;
  logic [7:0] got_count;
  tx_word_t tx_word;
  int bad_count = 0;
  int total_checks = 0;
  int falls = 0;
  int pops = 0;
  int cycles = 0;
  int k;
  // Bus level: device drives while its enable is low, the master otherwise
  assign bus_level = port_data_oe_n ? master_data : port_data_out;
  slave_fifo_command_port u_dut (.core_clk(core_clk), .resetn(resetn), .ce(1'b1),
    .port_select(port_select), .chip_select_n(chip_select_n), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .bus_output_enable(bus_output_enable),
    .packet_commit(commit), .interface_clock_in(interface_clock), .interface_clock_out(clk_out),
    .interface_clock_oe_n(clk_oe_n), .port_data_in(bus_level), .port_data_out(port_data_out),
    .port_data_oe_n(port_data_oe_n), .flag_out_a(flag_out_a), .flag_out_b(flag_out_b),
    .flag_out_c(flag_out_c), .ready(ready), .irq_n(irq_n), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .out_head(out_head), .out_pop(out_pop),
    .out_pop_ep(out_pop_ep), .out_arrive(out_arrive), .out_arrive_ep(arrive_ep),
    .in_sent(1'b0), .in_sent_ep(2'h0), .event_in(events));
  ep_model u_ep (.core_clk(core_clk), .resetn(resetn), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .hold(hold), .out_pop(out_pop),
    .out_head(out_head), .got_data(got_data), .got_ep(got_ep), .got_count(got_count));
  // Core clock and an unrelated interface clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #7;
    forever #80 interface_clock = ~interface_clock;
  end
  // Counts ready drops and pops, and cuts a hang short
  always @(posedge core_clk) begin
    ready_q <= ready;
    if (ready_q === 1'b1 && ready === 1'b0) falls <= falls + 1;
    if (out_pop === 1'b1 && out_pop_ep === 2'h0) pops <= pops + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      close_out();
    end
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobe held across exactly one rising interface clock edge
  task strobe(input logic rd, input logic cm = 1'b0);
    @(posedge interface_clock);
    @(negedge core_clk);
    if (cm) commit = 1'b0; else if (rd) read_strobe = 1'b0; else write_strobe = 1'b0;
    @(posedge interface_clock);
    repeat (3) @(negedge core_clk);
    read_strobe = 1'b1;
    write_strobe = 1'b1;
    commit = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  task cmd_byte(input logic [7:0] b);
    int f;
    for (k = 0; k < 50 && ready !== 1'b1; k++) @(negedge core_clk);
    f = falls;
    port_select = SEL_CMD;
    master_data = {8'h00, b};
    strobe(1'b0);
    for (k = 0; k < 50 && ready !== 1'b1; k++) @(negedge core_clk);
    check("ready drop", 16'(falls - f), 16'h1);
  endtask
  task write_reg(input logic [5:0] a, input logic [7:0] v);
    cmd_byte({2'b10, a});
    cmd_byte({4'h0, v[7:4]});
    cmd_byte({4'h0, v[3:0]});
  endtask
  task read_reg(input logic [5:0] a, input logic [7:0] v, input logic chk);
    cmd_byte({2'b11, a});
    for (k = 0; k < 50 && irq_n !== 1'b0; k++) @(negedge core_clk);
    check("irq", 16'(irq_n), 16'h0);
    bus_output_enable = 1'b0;
    repeat (5) @(negedge core_clk);
    check("bus on", 16'(port_data_oe_n), 16'h0);
    if (chk) check("reg", 16'(port_data_out[7:0]), 16'(v));
    strobe(1'b1);
    bus_output_enable = 1'b1;
    repeat (5) @(negedge core_clk);
    check("irq clear", 16'(irq_n), 16'h1);
    check("bus off", 16'(port_data_oe_n), 16'h1);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    repeat (5) @(negedge core_clk);
    check("ready", 16'(ready), 16'h1);
    check("irq", 16'(irq_n), 16'h1);
    check("clk in", 16'(clk_oe_n), 16'h1);
    check("empty", 16'(flag_out_c), 16'h1);
    check("pf out", 16'(flag_out_a), 16'h0);
    port_select = 3'h2;
    repeat (5) @(negedge core_clk);
    check("pf in", 16'(flag_out_a), 16'h1);
    $display("test reset done");
    read_reg(RA_PINPOL, 8'h00, 1'b1);
    read_reg(RA_COMMIT_POLARITY_REG, 8'h00, 1'b1);
    cmd_byte({2'b10, RA_FLAGMAP});
    cmd_byte(8'h00);
    write_reg(RA_FLAGMAP, 8'h03);
    read_reg(RA_FLAGMAP, 8'h03, 1'b1);
    read_reg(6'h3F, 8'h00, 1'b0);
    events = 8'h21;
    @(negedge core_clk);
    events = 8'h00;
    bus_output_enable = 1'b0;
    repeat (4) @(negedge core_clk);
    check("event irq", 16'(irq_n), 16'h0);
    check("status", 16'(port_data_out[7:0]), 16'h21);
    strobe(1'b1);
    bus_output_enable = 1'b1;
    repeat (4) @(negedge core_clk);
    check("status clear", 16'(irq_n), 16'h1);
    $display("test registers done");
    port_select = 3'h2;
    hold = 1'b1;
    master_data = 16'h005A;
    strobe(1'b0);
    master_data = 16'h00A5;
    strobe(1'b0);
    check("full", 16'(flag_out_b), 16'h1);
    master_data = 16'h0077;
    strobe(1'b0);
    hold = 1'b0;
    repeat (20) @(negedge core_clk);
    check("words", 16'(got_count), 16'h2);
    check("last", 16'(got_data[7:0]), 16'h00A5);
    check("ep", 16'(got_ep), 16'h2);
    write_reg(RA_WIDTH_BASE + 6'h2, 8'h01);
    port_select = 3'h2;
    master_data = 16'hC3A5;
    strobe(1'b0);
    repeat (20) @(negedge core_clk);
    check("wide", got_data, 16'hC3A5);
    check("pf pkt", 16'(flag_out_a), 16'h1);
    strobe(1'b0, 1'b1);
    check("commit", 16'(flag_out_a), 16'h0);
    $display("test fifo write done");
    port_select = 3'h0;
    out_arrive = 1'b1;
    @(negedge core_clk);
    out_arrive = 1'b0;
    repeat (5) @(negedge core_clk);
    check("pf 512", 16'(flag_out_a), 16'h1);
    check("not empty", 16'(flag_out_c), 16'h0);
    bus_output_enable = 1'b0;
    repeat (5) @(negedge core_clk);
    check("head", 16'(port_data_out[7:0]), 16'h0050);
    strobe(1'b1);
    check("pops", 16'(pops), 16'h1);
    $display("test fifo read done");
    chip_select_n = 1'b1;
    strobe(1'b1);
    check("cs float", 16'(port_data_oe_n), 16'h1);
    check("cs pops", 16'(pops), 16'h1);
    bus_output_enable = 1'b1;
    chip_select_n = 1'b0;
    port_select = 3'h5;
    k = falls;
    strobe(1'b0);
    strobe(1'b1);
    check("rsv words", 16'(got_count), 16'h3);
    check("rsv pops", 16'(pops), 16'h1);
    check("rsv ready", 16'(falls - k), 16'h0);
    $display("test ignore done");
    write_reg(RA_IFCFG, 8'h80);
    k = clk_out;
    check("clk drive", 16'(clk_oe_n), 16'h0);
    repeat (2) @(negedge core_clk);
    check("clk runs", 16'(clk_out ^ k[0]), 16'h1);
    $display("test clock done");
    close_out();
  end
endmodule
`default_nettype wire
